//--- pkg/lspic_regs.vh
// Summary of operation
// - control bit 5 reads 1 while the interrupt output is active.
// - control bit 4 reads 1 once an integration cycle has finished.
// - control bit 1 set starts integration on both channels; clear disables them.
// - control bit 0 set powers the device on; clear powers it off.
// - timing field is two's-complement count of 2.7 ms intervals.
// - timing value 0x01 gives longest automatic integration, 255 intervals.
// - timing register resets to zero, so manual mode at start.
// - timing value zero selects manual mode, length set by host commands.
// - control register resets to zero: powered off, converters disabled.
// - in manual mode, special function 0011 starts a manual integration.
// - in manual mode, special function 0010 ends a manual integration.
// - special function 00001 clears the pending interrupt and its flag.
`ifndef LSPIC_REGS_VH
`define LSPIC_REGS_VH
`define LSPIC_ADDR_CTRL 5'h00
`define LSPIC_ADDR_TIME 5'h01
`define LSPIC_CTRL_RST 8'h00
`define LSPIC_TIME_RST 8'h00
`define LSPIC_BIT_POWER 0
`define LSPIC_BIT_EN 1
`define LSPIC_BIT_VALID 4
`define LSPIC_BIT_INTR 5
`define LSPIC_SF_INTCLR 5'h01
`define LSPIC_SF_STOP 5'h02
`define LSPIC_SF_START 5'h03
`define LSPIC_CLK_HZ 40000000
`define LSPIC_STEP_NS 2700000
// cycles per 2.7 ms step at 40 MHz
`define LSPIC_STEP_CYC ((`LSPIC_STEP_NS / 1000) * (`LSPIC_CLK_HZ / 1000000))
`endif

//--- logic/lspic_step_timer.v
`timescale 1ns/1ps
`include "lspic_regs.vh"
// run-gated tick generator, one pulse per integration interval
module lspic_step_timer #(
	parameter STEP_CYC = `LSPIC_STEP_CYC
) (
	// clock and reset
	input wire i_mclk,
	input wire i_rstn,
	// control
	input wire i_run,
	// tick out
	output reg o_tick
);
	reg [23:0] cnt_r;

	// restart on each run so the first interval is whole
	always @(posedge i_mclk) begin
		if (!i_rstn || !i_run) begin
			cnt_r <= 24'h000000;
			o_tick <= 1'b0;
		end else if (cnt_r == STEP_CYC[23:0] - 24'h000001) begin
			cnt_r <= 24'h000000;
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 24'h000001;
			o_tick <= 1'b0;
		end
	end
endmodule // lspic_step_timer

//--- logic/lspic_ctrl.v
`timescale 1ns/1ps
`include "lspic_regs.vh"
// control and integration timing of the light converter
// the serial front end turns command bytes into the plain strobes below;
// word writes and auto-increment never reach this block, so a timing
// value above 127 arrives here like any other byte
// thresholds, persistence and gain sit outside; only their event comes in
module lspic_ctrl #(
	parameter STEP_CYC = `LSPIC_STEP_CYC
) (
	// clock and reset
	input wire i_mclk,
	input wire i_rstn,
	// register port from the serial front end
	input wire i_wr,
	input wire i_rd,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	output reg [7:0] o_rdata,
	// special function strobe with its code
	input wire i_sf,
	input wire [4:0] i_sf_code,
	// interrupt request from threshold logic
	input wire i_int_event,
	// converter side
	output wire o_power,
	output wire o_integrating,
	output reg o_cycle_done,
	output wire o_int_n
);
	// sequencer states
	localparam ST_IDLE = 2'h0; // waiting for enable or a manual start
	localparam ST_AUTO = 2'h1; // counting whole intervals
	localparam ST_MAN = 2'h2; // host-timed integration

	// programmed bits and read-only flags
	reg power_r;
	reg adc_en_r;
	reg valid_r;
	reg intr_r;
	reg [7:0] integration_time_count_r;
	reg [7:0] interval_count_r;

	// sequencer state and its next values
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [7:0] cnt_nxt;
	reg done_nxt;
	wire tick;
	wire active;
	wire manual;
	wire step_run;

	// decoded strobes from the serial front end
	wire wr_ctrl;
	wire wr_time;
	wire sf_clr;
	wire sf_stop;
	wire sf_start;

	// control byte as the host reads it
	wire [7:0] ctrl_byte;

	// next values of the registers below
	reg power_nxt;
	reg adc_en_nxt;
	reg [7:0] time_nxt;
	reg valid_nxt;
	reg intr_nxt;
	reg [7:0] rdata_nxt;

	// converters only run when powered and enabled
	assign active = power_r & adc_en_r;
	assign manual = (integration_time_count_r == 8'h00);
	assign o_power = power_r;
	assign o_integrating = (state_r != ST_IDLE);
	assign o_int_n = ~intr_r;
	// the interval timer only runs inside an automatic integration
	assign step_run = (state_r == ST_AUTO);

	// one decode per strobe; codes already arrive as plain numbers
	assign wr_ctrl = i_wr && (i_addr == `LSPIC_ADDR_CTRL);
	assign wr_time = i_wr && (i_addr == `LSPIC_ADDR_TIME);
	assign sf_clr = i_sf && (i_sf_code == `LSPIC_SF_INTCLR);
	assign sf_stop = i_sf && (i_sf_code == `LSPIC_SF_STOP);
	assign sf_start = i_sf && (i_sf_code == `LSPIC_SF_START);

	// reserved positions are hard zeros so no stray bits read back
	assign ctrl_byte = {2'b00, intr_r, valid_r, 2'b00, adc_en_r, power_r};

	lspic_step_timer #(
		.STEP_CYC(STEP_CYC)
	) u_step (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_run(step_run),
		.o_tick(tick)
	);

	// register write next values; reserved control bits are not stored
	always @* begin
		power_nxt = power_r;
		adc_en_nxt = adc_en_r;
		time_nxt = integration_time_count_r;
		// power and enable sit side by side so one write sets both
		if (wr_ctrl) begin
			power_nxt = i_wdata[`LSPIC_BIT_POWER];
			adc_en_nxt = i_wdata[`LSPIC_BIT_EN];
		end
		// a new timing value takes effect at the next integration start
		if (wr_time)
			time_nxt = i_wdata;
	end

	// control and timing registers
	always @(posedge i_mclk) begin
		if (!i_rstn) begin
			power_r <= 1'b0;
			adc_en_r <= 1'b0;
			integration_time_count_r <= `LSPIC_TIME_RST;
		end else begin
			power_r <= power_nxt;
			adc_en_r <= adc_en_nxt;
			integration_time_count_r <= time_nxt;
		end
	end

	// integration sequencer
	always @* begin
		state_nxt = state_r;
		cnt_nxt = interval_count_r;
		done_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				// auto mode rearms on its own; manual waits for a start
				if (active && !manual) begin
					state_nxt = ST_AUTO;
					cnt_nxt = integration_time_count_r;
				end else if (active && manual && sf_start) begin
					state_nxt = ST_MAN;
				end
			end
			ST_AUTO: begin
				// counting up to wrap gives 256 - value intervals
				if (tick) begin
					cnt_nxt = interval_count_r + 8'h01;
					if (interval_count_r == 8'hff) begin
						done_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_MAN: begin
				// no interval count here; the host decides the length
				if (sf_stop) begin
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// disable or power-off aborts at once
		if (!active) begin
			state_nxt = ST_IDLE;
			done_nxt = 1'b0;
		end
	end

	// sequencer registers; done leaves a flop so it never glitches
	always @(posedge i_mclk) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
			interval_count_r <= 8'h00;
			o_cycle_done <= 1'b0;
		end else begin
			state_r <= state_nxt;
			interval_count_r <= cnt_nxt;
			o_cycle_done <= done_nxt;
		end
	end

	// flag next values; a new event beats a clear in the same cycle
	always @* begin
		valid_nxt = valid_r;
		intr_nxt = intr_r;
		// valid only means something for the current enable session
		if (done_nxt)
			valid_nxt = 1'b1;
		else if (!active)
			valid_nxt = 1'b0;
		// events while disabled or unpowered are dropped, not queued
		if (i_int_event && active)
			intr_nxt = 1'b1;
		else if (sf_clr)
			intr_nxt = 1'b0;
	end

	// sticky flags
	always @(posedge i_mclk) begin
		if (!i_rstn) begin
			valid_r <= 1'b0;
			intr_r <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
			intr_r <= intr_nxt;
		end
	end

	// read data next value; reserved bits read zero
	always @* begin
		rdata_nxt = o_rdata;
		if (i_rd) begin
			// a read of an unmapped address still updates, to zero
			case (i_addr)
				`LSPIC_ADDR_CTRL: rdata_nxt = ctrl_byte;
				`LSPIC_ADDR_TIME: rdata_nxt = integration_time_count_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// data output from a flop; holds until the next read
	always @(posedge i_mclk) begin
		if (!i_rstn)
			o_rdata <= 8'h00;
		else
			o_rdata <= rdata_nxt;
	end
endmodule // lspic_ctrl

//--- bench/lspic_host.sv
`timescale 1ns/1ps
// host side of the register port, one strobe cycle per request
module lspic_host #(parameter PWR_WAIT = 80000) (input wire i_mclk, output reg o_wr, o_rd, o_sf,
	output reg [4:0] o_addr, o_code, output reg [7:0] o_wdata);
	initial {o_wr, o_rd, o_sf, o_addr, o_code, o_wdata} = 21'h0;
	// k: 0 write, 1 read, 2 special function; data inverted once released
	task req(input [1:0] k, input [4:0] a, input [7:0] d);
		begin
			@(negedge i_mclk);
			{o_wr, o_rd, o_sf} <= {k == 2'd0, k == 2'd1, k == 2'd2};
			o_addr <= a;
			o_code <= a;
			o_wdata <= d;
			@(negedge i_mclk);
			{o_wr, o_rd, o_sf} <= 3'b000;
			o_wdata <= ~d;
		end
	endtask
	// timing first, then power, settle, then enable
	task start(input [7:0] t);
		begin
			req(2'd0, 5'h01, t);
			req(2'd0, 5'h00, 8'h01);
			repeat (PWR_WAIT) @(negedge i_mclk);
			req(2'd0, 5'h00, 8'h03);
		end
	endtask
endmodule // lspic_host

//--- bench/lspic_chk.sv
`timescale 1ns/1ps
module lspic_chk (input wire i_mclk, i_rstn, i_wr, i_rd, i_sf, i_int_event, o_power, o_integrating,
	input wire o_cycle_done, o_int_n, input wire [4:0] i_addr, i_sf_code, input wire [7:0] i_wdata, o_rdata);
	reg [7:0] tm_r;
	reg en_r;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// shadow of host writes, so no design state is peeked
	always @(posedge i_mclk)
		if (!i_rstn) {tm_r, en_r} <= 9'h000;
		else if (i_wr && i_addr == 5'h01) tm_r <= i_wdata;
		else if (i_wr && i_addr == 5'h00) en_r <= i_wdata[1];
	chk_power_write:
	assert property (i_wr && i_addr == 5'h00 |=> o_power == $past(i_wdata[0])) else $error("power bit");
	chk_rst_idle:
	assert property (disable iff (1'b0) !i_rstn |=> !o_power && !o_integrating && o_int_n) else $error("reset");
	chk_en_off:
	assert property (i_wr && i_addr == 5'h00 && !i_wdata[1] |-> ##2 !o_integrating) else $error("enable off");
	chk_unpowered_idle:
	assert property (!o_power && $past(!o_power) |-> !o_integrating) else $error("unpowered");
	chk_ctrl_read:
	assert property (i_rd && i_addr == 5'h00 |=> o_rdata[5] == !$past(o_int_n) && o_rdata[3:2] == 2'b00
		&& o_rdata[7:6] == 2'b00 && o_rdata[1:0] == {$past(en_r), $past(o_power)}) else $error("ctrl read");
	chk_time_read:
	assert property (i_rd && i_addr == 5'h01 |=> o_rdata == $past(tm_r)) else $error("timing read");
	chk_manual_start:
	assert property (i_sf && i_sf_code == 5'h03 && tm_r == 8'h00 && o_power && en_r |=> o_integrating)
		else $error("start");
	chk_manual_stop:
	assert property (i_sf && i_sf_code == 5'h02 && tm_r == 8'h00 && o_power && en_r && o_integrating |=> o_cycle_done)
		else $error("stop");
	chk_manual_idle:
	assert property (o_cycle_done && tm_r == 8'h00 |=> !o_integrating) else $error("manual idle");
	chk_int_clear:
	assert property (i_sf && i_sf_code == 5'h01 && !i_int_event |=> o_int_n) else $error("int clear");
endmodule // lspic_chk
bind lspic_ctrl lspic_chk u_chk (.i_mclk, .i_rstn, .i_wr, .i_rd, .i_sf, .i_int_event, .o_power, .o_integrating,
	.o_cycle_done, .o_int_n, .i_addr, .i_sf_code, .i_wdata, .o_rdata);

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg i_mclk = 1'b0;
	reg i_rstn = 1'b0;
	reg i_int_event = 1'b0;
	reg rd_q = 1'b0;
	reg [7:0] exp_q[$];
	wire i_wr, i_rd, i_sf, o_power, o_integrating, o_cycle_done, o_int_n;
	wire [4:0] i_addr, i_sf_code;
	wire [7:0] i_wdata, o_rdata;
	integer n_errors = 0, checked = 0, seed = 32'h2fde, n, i;
	always #12.5 i_mclk = ~i_mclk;
	// short step keeps the 255-step case near a thousand cycles
	lspic_ctrl #(.STEP_CYC(4)) DUT (.i_mclk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .i_sf,
		.i_sf_code, .i_int_event, .o_power, .o_integrating, .o_cycle_done, .o_int_n);
	lspic_host #(.PWR_WAIT(40)) host (.i_mclk, .o_wr(i_wr), .o_rd(i_rd), .o_sf(i_sf), .o_addr(i_addr),
		.o_code(i_sf_code), .o_wdata(i_wdata));
	task cmp(input string s, input [7:0] e, input [7:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("[ERR] %s exp %h got %h", s, e, g);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("errors %0d checks %0d", n_errors, checked);
			if (n_errors == 0 && checked > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	task rd(input [4:0] a, input [7:0] e);
		begin
			exp_q.push_back(e);
			host.req(2'd1, a, 8'h00);
		end
	endtask
	// bounded wait for the done pulse, n counts cycles waited
	task wait_done;
		begin
			n = 0;
			while (o_cycle_done !== 1'b1 && n < 3000) begin
				@(negedge i_mclk);
				n = n + 1;
			end
			if (o_cycle_done !== 1'b1) begin
				n_errors = n_errors + 1;
				wrap_up;
			end
			@(negedge i_mclk);
		end
	endtask
	// read data lands one cycle after the strobe
	always @(posedge i_mclk) rd_q <= i_rd;
	always @(negedge i_mclk) if (rd_q) cmp("rdata", exp_q.pop_front(), o_rdata);
	initial begin
		repeat (3) @(negedge i_mclk);
		i_rstn = 1'b1;
		rd(5'h00, 8'h00);
		rd(5'h01, 8'h00);
		rd(5'h1f, 8'h00);
		$display("reset test done");
		host.start(8'hff);
		wait_done;
		rd(5'h00, 8'h13);
		@(negedge i_mclk) i_int_event = 1'b1;
		@(negedge i_mclk) i_int_event = 1'b0;
		rd(5'h00, 8'h33);
		host.req(2'd2, 5'h01, 8'h00);
		rd(5'h00, 8'h13);
		$display("auto test done");
		host.req(2'd0, 5'h01, 8'h01);
		wait_done;
		wait_done;
		cmp("period", 8'h01, {7'h00, n > 1018 && n < 1026});
		for (i = 0; i < 3; i = i + 1) begin
			n = $random(seed);
			host.req(2'd0, 5'h01, {1'b0, n[6:0]});
			rd(5'h01, {1'b0, n[6:0]});
		end
		$display("timing test done");
		host.start(8'h00);
		cmp("idle", 8'h00, {7'h00, o_integrating});
		host.req(2'd2, 5'h03, 8'h00);
		cmp("run", 8'h01, {7'h00, o_integrating});
		host.req(2'd2, 5'h02, 8'h00);
		wait_done;
		cmp("stop", 8'h01, {7'h00, n < 3});
		host.req(2'd2, 5'h03, 8'h00);
		host.req(2'd0, 5'h00, 8'h02);
		host.req(2'd2, 5'h03, 8'h00);
		repeat (3) @(negedge i_mclk);
		cmp("off", 8'h00, {7'h00, o_integrating});
		rd(5'h00, 8'h02);
		repeat (2) @(negedge i_mclk);
		$display("manual test done");
		wrap_up;
	end
endmodule // tb_top
